// *** common/cpwm_defines.vh ***
`ifndef CPWM_DEFINES_VH
`define CPWM_DEFINES_VH

// Register offsets on the plain register port
`define CPWM_ADDR_W             8
`define CPWM_OFF_GLOBAL_IRQ     8'h0B
`define CPWM_OFF_FLAGS_ONE      8'h0C
`define CPWM_OFF_FLAGS_TWO      8'h0D
`define CPWM_OFF_T1_LOW         8'h0E
`define CPWM_OFF_T1_HIGH        8'h0F
`define CPWM_OFF_T1_CTRL        8'h10
`define CPWM_OFF_U1_LOW         8'h15
`define CPWM_OFF_U1_HIGH        8'h16
`define CPWM_OFF_U1_CTRL        8'h17
`define CPWM_OFF_U2_LOW         8'h1B
`define CPWM_OFF_U2_HIGH        8'h1C
`define CPWM_OFF_U2_CTRL        8'h1D
`define CPWM_OFF_PORTC_DIR      8'h87
`define CPWM_OFF_ENABLES_ONE    8'h8C
`define CPWM_OFF_ENABLES_TWO    8'h8D
`define CPWM_OFF_T2_COUNT       8'h30
`define CPWM_OFF_T2_CTRL        8'h31
`define CPWM_OFF_T2_PERIOD      8'h32
`define CPWM_OFF_CLEAR_ONE      8'h33
`define CPWM_OFF_CLEAR_TWO      8'h34

// Reset values
`define CPWM_RST_ZERO           8'h00
`define CPWM_RST_PORTC_DIR      8'hFF
`define CPWM_RST_T2_PERIOD      8'hFF

// Field positions
`define CPWM_BIT_T1_OVF         0
`define CPWM_BIT_T2_HIT         1
`define CPWM_BIT_U1_MATCH       2
`define CPWM_BIT_U2_MATCH       0
`define CPWM_BIT_GIE            7
`define CPWM_BIT_PEIE           6
`define CPWM_BIT_T1_ON          0
`define CPWM_BIT_T2_ON          2
`define CPWM_BIT_U1_DIR         2
`define CPWM_BIT_U2_DIR         1
`define CPWM_CTRL_MASK          8'h3F
`define CPWM_GIC_MASK           8'hC0
`define CPWM_T1CTRL_MASK        8'h3F
`define CPWM_T2CTRL_MASK        8'h07

// Unit mode field codes
`define CPWM_MODE_OFF           4'h0
`define CPWM_MODE_CMP_SET       4'h8
`define CPWM_MODE_CMP_CLR       4'h9
`define CPWM_MODE_CMP_SOFT      4'hA
`define CPWM_MODE_CMP_TRIG      4'hB
`define CPWM_MODE_CMP_HI        2'b10
`define CPWM_MODE_PWM_HI        2'b11

// Timer-two prescale selections and their terminal counts
`define CPWM_PRE_DIV1           2'b00
`define CPWM_PRE_DIV4           2'b01
`define CPWM_PRE_LAST_DIV1      4'h0
`define CPWM_PRE_LAST_DIV4      4'h3
`define CPWM_PRE_LAST_DIV16     4'hF
`define CPWM_PHASE_LAST         2'h3

`endif

// *** logic/cpwm_unit.v ***
`timescale 1ns/1ps
module cpwm_unit (
    input  wire        mclk,
    input  wire        reset_n,
    input  wire        ce,
    input  wire [3:0]  mode,
    input  wire        ctrl_zero_wr,
    input  wire [15:0] value,
    input  wire [15:0] count,
    input  wire [9:0]  duty,
    input  wire [9:0]  phase,
    input  wire        period_hit,
    output wire        hit,
    output wire        trigger,
    output wire        pin_level
);
`include "cpwm_defines.vh"

    reg       latch;
    reg       pwm_q;
    reg [9:0] duty_lat;

    wire cmp_mode = (mode[3:2] == `CPWM_MODE_CMP_HI);
    wire pwm_mode = (mode[3:2] == `CPWM_MODE_PWM_HI);

    // Equality every cycle; zero mode yields nothing
    assign hit       = cmp_mode & (value == count);
    assign trigger   = hit & (mode == `CPWM_MODE_CMP_TRIG);
    assign pin_level = pwm_mode ? pwm_q : latch;

    ////////////////////////////////////////////////////////////////////////
    // Compare output latch; a zeroed control wins over any match
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            latch <= 1'b0;
        end else if (ce) begin
            if (ctrl_zero_wr || mode == `CPWM_MODE_OFF) begin
                latch <= 1'b0;
            end else if (hit && mode == `CPWM_MODE_CMP_SET) begin
                latch <= 1'b1;
            end else if (hit && mode == `CPWM_MODE_CMP_CLR) begin
                latch <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Duty is reloaded only at period end, so a mid-period write never glitches
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_q    <= 1'b0;
            duty_lat <= 10'h000;
        end else if (ce) begin
            if (!pwm_mode) begin
                pwm_q <= 1'b0;
            end else if (period_hit) begin
                duty_lat <= duty;
                pwm_q    <= (duty != 10'h000);
            end else if (phase == duty_lat - 10'h001) begin                 // Registered level, so stop one phase early
                pwm_q <= 1'b0;
            end
        end
    end

endmodule // cpwm_unit

// *** logic/cpwm_top.v ***
// What this block does
// - Compare value with timer-one count every cycle
// - Match drives pin high, low, or unchanged
// - Match flag set in same cycle
// - Zeroing control register forces latch low
// - Software-interrupt mode: flag only, pin untouched
// - Unit-one trigger clears timer-one count
// - Unit-two trigger clears timer, starts conversion
// - Trigger reset never sets timer overflow flag
// - Timer-two prescaler divides by 1, 4, 16
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module cpwm_top (
    input  wire       mclk,
    input  wire       reset_n,
    input  wire       ce,
    input  wire [7:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata,
    input  wire       adc_enabled,
    output reg        adc_start,
    output reg        unit1_output_pin,
    output reg        unit1_output_pin_oe_n,
    output reg        unit2_output_pin,
    output reg        unit2_output_pin_oe_n,
    output reg        irq
);
`include "cpwm_defines.vh"

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    reg  [7:0]  global_interrupt_control;
    reg  [7:0]  peripheral_flags_one;
    reg  [7:0]  peripheral_flags_two;
    reg  [15:0] timer_one_count;
    reg  [7:0]  timer_one_control;
    reg  [7:0]  unit1_value_low;
    reg  [7:0]  unit1_value_high;
    reg  [7:0]  unit1_control;
    reg  [7:0]  unit2_value_low;
    reg  [7:0]  unit2_value_high;
    reg  [7:0]  unit2_control;
    reg  [7:0]  port_c_direction;
    reg  [7:0]  peripheral_enables_one;
    reg  [7:0]  peripheral_enables_two;
    reg  [7:0]  timer_two_count;
    reg  [7:0]  timer_two_control;
    reg  [7:0]  timer_two_period;
    reg  [3:0]  pre_count;
    reg  [1:0]  phase_fine;
    reg  [7:0]  next_rdata;

    wire        u1_hit;
    wire        u1_trig;
    wire        u1_level;
    wire        u2_hit;
    wire        u2_trig;
    wire        u2_level;

    // Decoded writes
    wire wr_gic    = wr && (addr == `CPWM_OFF_GLOBAL_IRQ);
    wire wr_t1l    = wr && (addr == `CPWM_OFF_T1_LOW);
    wire wr_t1h    = wr && (addr == `CPWM_OFF_T1_HIGH);
    wire wr_t1c    = wr && (addr == `CPWM_OFF_T1_CTRL);
    wire wr_u1l    = wr && (addr == `CPWM_OFF_U1_LOW);
    wire wr_u1h    = wr && (addr == `CPWM_OFF_U1_HIGH);
    wire wr_u1c    = wr && (addr == `CPWM_OFF_U1_CTRL);
    wire wr_u2l    = wr && (addr == `CPWM_OFF_U2_LOW);
    wire wr_u2h    = wr && (addr == `CPWM_OFF_U2_HIGH);
    wire wr_u2c    = wr && (addr == `CPWM_OFF_U2_CTRL);
    wire wr_dir    = wr && (addr == `CPWM_OFF_PORTC_DIR);
    wire wr_en1    = wr && (addr == `CPWM_OFF_ENABLES_ONE);
    wire wr_en2    = wr && (addr == `CPWM_OFF_ENABLES_TWO);
    wire wr_t2cnt  = wr && (addr == `CPWM_OFF_T2_COUNT);
    wire wr_t2c    = wr && (addr == `CPWM_OFF_T2_CTRL);
    wire wr_t2p    = wr && (addr == `CPWM_OFF_T2_PERIOD);
    wire wr_clr1   = wr && (addr == `CPWM_OFF_CLEAR_ONE);
    wire wr_clr2   = wr && (addr == `CPWM_OFF_CLEAR_TWO);

    // Whole control register written as zero
    wire u1_zero_wr = wr_u1c && (wdata == `CPWM_RST_ZERO);
    wire u2_zero_wr = wr_u2c && (wdata == `CPWM_RST_ZERO);

    ////////////////////////////////////////////////////////////////////////
    // Timer two time base: fine phase runs every clock while timer two is on, the count
    // advances once per four clocks times the prescale ratio
    wire [3:0] pre_last = (timer_two_control[1:0] == `CPWM_PRE_DIV1) ? `CPWM_PRE_LAST_DIV1 :
                          (timer_two_control[1:0] == `CPWM_PRE_DIV4) ? `CPWM_PRE_LAST_DIV4 :
                                                                        `CPWM_PRE_LAST_DIV16;
    wire t2_on      = timer_two_control[`CPWM_BIT_T2_ON];
    wire t2_tick    = t2_on && (phase_fine == `CPWM_PHASE_LAST) && (pre_count == pre_last);
    wire period_hit = t2_tick && (timer_two_count == timer_two_period);
    wire [9:0] pwm_phase = {timer_two_count, phase_fine};

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phase_fine      <= 2'h0;
            pre_count       <= 4'h0;
            timer_two_count <= `CPWM_RST_ZERO;
        end else if (ce) begin
            if (wr_t2cnt) begin
                timer_two_count <= wdata;
                pre_count       <= 4'h0;
            end else if (t2_on) begin
                phase_fine <= phase_fine + 2'h1;
                if (phase_fine == `CPWM_PHASE_LAST) begin
                    pre_count <= (pre_count == pre_last) ? 4'h0 : pre_count + 4'h1;
                end
                if (period_hit) begin
                    timer_two_count <= `CPWM_RST_ZERO;
                end else if (t2_tick) begin
                    timer_two_count <= timer_two_count + 8'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare / PWM units, one logic block each
    cpwm_unit u_unit1 (
        .mclk         (mclk),
        .reset_n      (reset_n),
        .ce           (ce),
        .mode         (unit1_control[3:0]),
        .ctrl_zero_wr (u1_zero_wr),
        .value        ({unit1_value_high, unit1_value_low}),
        .count        (timer_one_count),
        .duty         ({unit1_value_low, unit1_control[5:4]}),
        .phase        (pwm_phase),
        .period_hit   (period_hit),
        .hit          (u1_hit),
        .trigger      (u1_trig),
        .pin_level    (u1_level)
    );

    cpwm_unit u_unit2 (
        .mclk         (mclk),
        .reset_n      (reset_n),
        .ce           (ce),
        .mode         (unit2_control[3:0]),
        .ctrl_zero_wr (u2_zero_wr),
        .value        ({unit2_value_high, unit2_value_low}),
        .count        (timer_one_count),
        .duty         ({unit2_value_low, unit2_control[5:4]}),
        .phase        (pwm_phase),
        .period_hit   (period_hit),
        .hit          (u2_hit),
        .trigger      (u2_trig),
        .pin_level    (u2_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // Timer one: software write beats trigger clear beats increment.
    // Counts on mclk only, so the synchronous-mode requirement is met.
    wire t1_on    = timer_one_control[`CPWM_BIT_T1_ON];
    wire any_trig = u1_trig | u2_trig;
    wire t1_ovf   = t1_on && !any_trig && !wr_t1l && !wr_t1h &&
                    (timer_one_count == 16'hFFFF);

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            timer_one_count <= 16'h0000;
        end else if (ce) begin
            if (wr_t1l) begin
                timer_one_count[7:0] <= wdata;
            end else if (wr_t1h) begin
                timer_one_count[15:8] <= wdata;
            end else if (any_trig) begin
                timer_one_count <= 16'h0000;
            end else if (t1_on) begin
                timer_one_count <= timer_one_count + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion start pulse, only while the converter is enabled
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            adc_start <= 1'b0;
        end else if (ce) begin
            adc_start <= u2_trig & adc_enabled;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Plain software registers
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            global_interrupt_control <= `CPWM_RST_ZERO;
            timer_one_control        <= `CPWM_RST_ZERO;
            unit1_value_low          <= `CPWM_RST_ZERO;
            unit1_value_high         <= `CPWM_RST_ZERO;
            unit1_control            <= `CPWM_RST_ZERO;
            unit2_value_low          <= `CPWM_RST_ZERO;
            unit2_value_high         <= `CPWM_RST_ZERO;
            unit2_control            <= `CPWM_RST_ZERO;
            port_c_direction         <= `CPWM_RST_PORTC_DIR;
            peripheral_enables_one   <= `CPWM_RST_ZERO;
            peripheral_enables_two   <= `CPWM_RST_ZERO;
            timer_two_control        <= `CPWM_RST_ZERO;
            timer_two_period         <= `CPWM_RST_T2_PERIOD;
        end else if (ce) begin
            if (wr_gic) global_interrupt_control <= wdata & `CPWM_GIC_MASK;
            if (wr_t1c) timer_one_control <= wdata & `CPWM_T1CTRL_MASK;
            if (wr_u1l) unit1_value_low <= wdata;
            if (wr_u1h) unit1_value_high <= wdata;
            if (wr_u1c) unit1_control <= wdata & `CPWM_CTRL_MASK;
            if (wr_u2l) unit2_value_low <= wdata;
            if (wr_u2h) unit2_value_high <= wdata;
            if (wr_u2c) unit2_control <= wdata & `CPWM_CTRL_MASK;
            if (wr_dir) port_c_direction <= wdata;
            if (wr_en1) peripheral_enables_one <= wdata;
            if (wr_en2) peripheral_enables_two <= wdata;
            if (wr_t2c) timer_two_control <= wdata & `CPWM_T2CTRL_MASK;
            if (wr_t2p) timer_two_period <= wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags: a set in the same cycle as its clear wins
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            peripheral_flags_one <= `CPWM_RST_ZERO;
            peripheral_flags_two <= `CPWM_RST_ZERO;
        end else if (ce) begin
            peripheral_flags_one <= (peripheral_flags_one & ~(wr_clr1 ? wdata : 8'h00))
                | ({7'h00, t1_ovf} << `CPWM_BIT_T1_OVF)
                | ({7'h00, period_hit} << `CPWM_BIT_T2_HIT)
                | ({7'h00, u1_hit} << `CPWM_BIT_U1_MATCH);
            peripheral_flags_two <= (peripheral_flags_two & ~(wr_clr2 ? wdata : 8'h00))
                | ({7'h00, u2_hit} << `CPWM_BIT_U2_MATCH);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt level, gated by global and peripheral enables
    wire pend = |(peripheral_flags_one & peripheral_enables_one) |
                |(peripheral_flags_two & peripheral_enables_two);

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= pend & global_interrupt_control[`CPWM_BIT_GIE]
                        & global_interrupt_control[`CPWM_BIT_PEIE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins: the direction bit decides drive; pin follows the latch (the PWM level in PWM mode),
    // so it lags the match flag and the latch by one clock each
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            unit1_output_pin      <= 1'b0;
            unit1_output_pin_oe_n <= 1'b1;
            unit2_output_pin      <= 1'b0;
            unit2_output_pin_oe_n <= 1'b1;
        end else if (ce) begin
            unit1_output_pin      <= u1_level;
            unit1_output_pin_oe_n <= port_c_direction[`CPWM_BIT_U1_DIR];
            unit2_output_pin      <= u2_level;
            unit2_output_pin_oe_n <= port_c_direction[`CPWM_BIT_U2_DIR];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped and write-only addresses read zero
    always @* begin
        case (addr)
            `CPWM_OFF_GLOBAL_IRQ:   next_rdata = global_interrupt_control;
            `CPWM_OFF_FLAGS_ONE:    next_rdata = peripheral_flags_one;
            `CPWM_OFF_FLAGS_TWO:    next_rdata = peripheral_flags_two;
            `CPWM_OFF_T1_LOW:       next_rdata = timer_one_count[7:0];
            `CPWM_OFF_T1_HIGH:      next_rdata = timer_one_count[15:8];
            `CPWM_OFF_T1_CTRL:      next_rdata = timer_one_control;
            `CPWM_OFF_U1_LOW:       next_rdata = unit1_value_low;
            `CPWM_OFF_U1_HIGH:      next_rdata = unit1_value_high;
            `CPWM_OFF_U1_CTRL:      next_rdata = unit1_control;
            `CPWM_OFF_U2_LOW:       next_rdata = unit2_value_low;
            `CPWM_OFF_U2_HIGH:      next_rdata = unit2_value_high;
            `CPWM_OFF_U2_CTRL:      next_rdata = unit2_control;
            `CPWM_OFF_PORTC_DIR:    next_rdata = port_c_direction;
            `CPWM_OFF_ENABLES_ONE:  next_rdata = peripheral_enables_one;
            `CPWM_OFF_ENABLES_TWO:  next_rdata = peripheral_enables_two;
            `CPWM_OFF_T2_COUNT:     next_rdata = timer_two_count;
            `CPWM_OFF_T2_CTRL:      next_rdata = timer_two_control;
            `CPWM_OFF_T2_PERIOD:    next_rdata = timer_two_period;
            default:                next_rdata = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 8'h00;
        end else if (ce) begin
            rdata <= rd ? next_rdata : 8'h00;
        end
    end

endmodule // cpwm_top

// *** verif/cpwm_checker.sv ***
`timescale 1ns/1ps
`include "cpwm_defines.vh"
module cpwm_checker (
    input wire       mclk,
    input wire       reset_n,
    input wire       ce,
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata,
    input wire       adc_enabled,
    input wire       adc_start,
    input wire       unit1_output_pin,
    input wire       unit1_output_pin_oe_n,
    input wire       unit2_output_pin,
    input wire       unit2_output_pin_oe_n,
    input wire       irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    logic       irq_on;
    logic       dir1;
    logic [3:0] u1m;
    logic [3:0] u2m;
    wire        bus_wr = ce && wr;

    ////////////////////////////////////////////////////////////
    // Shadows of gating registers, since only the bus is visible here
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_on <= 1'b0;
            dir1   <= 1'b1;
            u1m    <= `CPWM_MODE_OFF;
            u2m    <= `CPWM_MODE_OFF;
        end else if (bus_wr) begin
            if (addr == `CPWM_OFF_GLOBAL_IRQ) irq_on <= wdata[7] & wdata[6];
            if (addr == `CPWM_OFF_PORTC_DIR) dir1 <= wdata[`CPWM_BIT_U1_DIR];
            if (addr == `CPWM_OFF_U1_CTRL) u1m <= wdata[3:0];
            if (addr == `CPWM_OFF_U2_CTRL) u2m <= wdata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////
    zero_clear_a: assert property ((bus_wr && addr == `CPWM_OFF_U1_CTRL && wdata == 8'h00) ##1 ce
        |=> !unit1_output_pin) else $error("pin1 high after control cleared");
    idle_pin1_a: assert property ((ce && u1m == `CPWM_MODE_OFF) ##1 ce |=> !unit1_output_pin)
        else $error("pin1 high while unit off");
    idle_pin2_a: assert property ((ce && u2m == `CPWM_MODE_OFF) ##1 ce |=> !unit2_output_pin)
        else $error("pin2 high while unit off");
    adc_gate_a: assert property (ce && !adc_enabled |=> !adc_start)
        else $error("conversion start with converter off");
    adc_trig_only_a: assert property (ce && u2m != `CPWM_MODE_CMP_TRIG |=> !adc_start)
        else $error("conversion start outside trigger mode");
    irq_masked_a: assert property (ce && !irq_on |=> !irq)
        else $error("interrupt while globally masked");
    soft_pin_hold_a: assert property ((u1m == `CPWM_MODE_CMP_SOFT && !(wr && addr == `CPWM_OFF_U1_CTRL))
        |=> ##1 $stable(unit1_output_pin)) else $error("pin1 moved in flag-only mode");
    oe_follow_a: assert property ((ce && $stable(dir1)) [*3] |-> unit1_output_pin_oe_n == dir1)
        else $error("pin1 drive enable differs from direction bit");
endmodule // cpwm_checker

// *** verif/cpwm_pin_load.sv ***
`timescale 1ns/1ps
module cpwm_pin_load (
    input  wire pin,
    input  wire oe_n,
    output wire level
);
    // Weak pull-up owns the node whenever the unit lets go of it
    assign level = oe_n ? 1'b1 : pin;
endmodule // cpwm_pin_load

// *** verif/tb_cpwm_top.sv ***
`timescale 1ns/1ps
`include "cpwm_defines.vh"
module tb_cpwm_top;
    logic        mclk, reset_n, ce, wr, rd, adc_enabled, mon, p1_last, pin_exp;
    logic [7:0]  addr, wdata, base;
    logic [15:0] v;
    logic [9:0]  d;
    wire  [7:0]  rdata;
    wire         adc_start, irq, pin1, oe1_n, pin2, oe2_n, lvl1, lvl2;
    int          errors, total_checks, n, h, p;
    logic [7:0]  ra [6] = '{8'h87, 8'h17, 8'h32, 8'h0C, 8'h40, 8'h33};
    logic [7:0]  re [6] = '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
    logic [3:0]  modes [4] = '{4'h8, 4'hA, 4'h9, 4'h8};

    cpwm_top cpwm_top_inst (.mclk(mclk), .reset_n(reset_n), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .adc_enabled(adc_enabled), .adc_start(adc_start),
        .unit1_output_pin(pin1), .unit1_output_pin_oe_n(oe1_n), .unit2_output_pin(pin2),
        .unit2_output_pin_oe_n(oe2_n), .irq(irq));
    cpwm_pin_load load1 (.pin(pin1), .oe_n(oe1_n), .level(lvl1));
    cpwm_pin_load load2 (.pin(pin2), .oe_n(oe2_n), .level(lvl2));

    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] dat);
        @(posedge mclk);
        addr <= a;
        wdata <= dat;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk("rdata", 16'(rdata), 16'(e));
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // Park the stopped timer just below the target and let it run past
    task automatic pass_value(input logic [15:0] at);
        wreg(`CPWM_OFF_T1_HIGH, at[15:8]);
        wreg(`CPWM_OFF_T1_LOW, at[7:0]);
        wreg(`CPWM_OFF_T1_CTRL, 8'h01);
        repeat (8) @(posedge mclk);
        wreg(`CPWM_OFF_T1_CTRL, 8'h00);
    endtask
    task automatic wait_lvl(input logic b);
        repeat (600) if (lvl1 !== b) tick(1);
    endtask
    // Width of the high phase and of one full cycle on the pin
    task automatic measure(output int hi, output int per);
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        for (hi = 0; lvl1 === 1'b1 && hi < 600; hi++) tick(1);
        for (per = hi; lvl1 === 1'b0 && per < 600; per++) tick(1);
    endtask
    function automatic logic exp_pin(input logic [3:0] m, input logic prev);
        if (m == `CPWM_MODE_CMP_SET) return 1'b1;
        if (m == `CPWM_MODE_CMP_CLR) return 1'b0;
        return prev;
    endfunction
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Pin and interrupt have to move in the same cycle on a match
    always @(posedge mclk) begin
        if (mon && pin1 !== p1_last) chk("irq at pin move", 16'(irq), 16'h1);
        p1_last <= pin1;
        if (!reset_n) n <= 0;
        else if (adc_start === 1'b1) n <= n + 1;
    end
    initial begin
        #400000;
        errors++;
        finish_test();
    end
    initial begin
        {wr, rd, addr, wdata, adc_enabled, mon, pin_exp} = '0;
        {errors, total_checks} = '0;
        ce = 1'b1;
        reset_n = 1'b0;
        void'($urandom(32'h185D));
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        // Reset values, an unmapped place and the write-only clear
        for (int i = 0; i < 6; i++) rchk(ra[i], re[i]);
        chk("oe1 reset", 16'(oe1_n), 16'h1);
        chk("oe2 reset", 16'(oe2_n), 16'h1);
        wreg(`CPWM_OFF_PORTC_DIR, 8'hF9);
        wreg(`CPWM_OFF_ENABLES_ONE, 8'h04);
        wreg(`CPWM_OFF_GLOBAL_IRQ, 8'hC0);
        tick(2);
        chk("oe1 drive", 16'(oe1_n), 16'h0);
        chk("oe2 drive", 16'(oe2_n), 16'h0);
        mon = 1'b1;
        foreach (modes[i]) begin
            v = 16'h0100 + 16'($urandom % 32'hFE00);
            pin_exp = exp_pin(modes[i], pin_exp);
            wreg(`CPWM_OFF_CLEAR_ONE, 8'hFF);
            wreg(`CPWM_OFF_U1_LOW, v[7:0]);
            wreg(`CPWM_OFF_U1_HIGH, v[15:8]);
            wreg(`CPWM_OFF_U1_CTRL, {4'h0, modes[i]});
            pass_value(v - 16'h3);
            tick(2);
            chk("pin1", 16'(lvl1), 16'(pin_exp));
            chk("irq", 16'(irq), 16'h1);
            rchk(`CPWM_OFF_FLAGS_ONE, 8'h04);
        end
        mon = 1'b0;
        // Level interrupt through mask, unmask and clear
        wreg(`CPWM_OFF_ENABLES_ONE, 8'h00);
        tick(2);
        chk("irq masked", 16'(irq), 16'h0);
        wreg(`CPWM_OFF_ENABLES_ONE, 8'h04);
        tick(2);
        chk("irq unmasked", 16'(irq), 16'h1);
        wreg(`CPWM_OFF_CLEAR_ONE, 8'h04);
        tick(2);
        chk("irq cleared", 16'(irq), 16'h0);
        wreg(`CPWM_OFF_U1_CTRL, 8'h00);
        tick(2);
        chk("pin1 cleared", 16'(lvl1), 16'h0);
        pass_value(v - 16'h3);
        rchk(`CPWM_OFF_FLAGS_ONE, 8'h00);
        pass_value(16'hFFFA);
        rchk(`CPWM_OFF_FLAGS_ONE, 8'h01);
        // Trigger from each unit, converter on and then off for unit two
        for (int u = 0; u < 3; u++) begin
            v = 16'h0100 + 16'($urandom % 32'hFE00);
            base = (u == 0) ? `CPWM_OFF_U1_LOW : `CPWM_OFF_U2_LOW;
            adc_enabled <= (u == 1);
            wreg(`CPWM_OFF_CLEAR_ONE, 8'hFF);
            wreg(`CPWM_OFF_CLEAR_TWO, 8'hFF);
            wreg(base, v[7:0]);
            wreg(base + 8'h1, v[15:8]);
            wreg(base + 8'h2, 8'h0B);
            p = n;
            pass_value(v - 16'h3);
            rchk(`CPWM_OFF_T1_HIGH, 8'h00);
            rchk(`CPWM_OFF_FLAGS_ONE, (u == 0) ? 8'h04 : 8'h00);
            rchk(`CPWM_OFF_FLAGS_TWO, (u == 0) ? 8'h00 : 8'h01);
            chk("adc starts", 16'(n - p), (u == 1) ? 16'h1 : 16'h0);
            wreg(base + 8'h2, 8'h00);
        end
        // Unit two drives its own pin on a match and drops it on a zeroed control
        wreg(`CPWM_OFF_U2_CTRL, 8'h08);
        pass_value(v - 16'h3);
        tick(2);
        chk("pin2", 16'(lvl2), 16'h1);
        wreg(`CPWM_OFF_U2_CTRL, 8'h00);
        tick(2);
        chk("pin2 cleared", 16'(lvl2), 16'h0);
        // PWM at each prescale; setup keeps the documented order
        for (int s = 0; s < 3; s++) begin
            d = 10'(1 + $urandom % 15);
            wreg(`CPWM_OFF_T2_PERIOD, 8'h03);
            wreg(`CPWM_OFF_U1_LOW, d[9:2]);
            wreg(`CPWM_OFF_U1_CTRL, {2'b00, d[1:0], 4'h0});
            wreg(`CPWM_OFF_T2_CTRL, {6'h01, 2'(s)});
            wreg(`CPWM_OFF_U1_CTRL, {2'b00, d[1:0], 4'hC});
            measure(h, p);
            measure(h, p);
            chk("pwm period", 16'(p), 16'(16 << (2 * s)));
            if (s == 0) chk("pwm high", 16'(h), 16'(d));
        end
        finish_test();
    end
endmodule // tb_cpwm_top

bind cpwm_top cpwm_checker cpwm_checker_inst (.mclk(mclk), .reset_n(reset_n), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .adc_enabled(adc_enabled), .adc_start(adc_start),
    .unit1_output_pin(unit1_output_pin), .unit1_output_pin_oe_n(unit1_output_pin_oe_n),
    .unit2_output_pin(unit2_output_pin), .unit2_output_pin_oe_n(unit2_output_pin_oe_n), .irq(irq));
